// ==== include/bmr_pkg.sv ====
// package: constants and types for the boot mode select and memory remap block
package bmr_pkg;
    // =========================================================
    // address map
    localparam logic [31:0] BMR_BOOT_BASE = 32'h0000_0000;
    localparam logic [31:0] BMR_FLASH_BASE = 32'h0800_0000;
    localparam logic [31:0] BMR_SYSMEM_BASE = 32'h1fff_ec00;
    localparam logic [31:0] BMR_SRAM_BASE = 32'h2000_0000;
    // default window sizes, flash and system memory in bytes, sram in words
    localparam logic [31:0] BMR_FLASH_BYTES = 32'h0001_0000;
    localparam logic [31:0] BMR_SYSMEM_BYTES = 32'h0000_1400;
    localparam int BMR_SRAM_WORDS = 2048;
    // =========================================================
    // startup selection
    typedef enum logic [1:0] {
        BMR_BOOT_FLASH = 2'b00,
        BMR_BOOT_SYSMEM = 2'b01,
        BMR_BOOT_SRAM = 2'b10
    } bmr_boot_e;
    localparam bmr_boot_e BMR_BOOT_RESET = BMR_BOOT_FLASH;
    // =========================================================
    // region reached by an access
    typedef enum logic [1:0] {
        BMR_REG_NONE = 2'b00,
        BMR_REG_FLASH = 2'b01,
        BMR_REG_SYSMEM = 2'b10,
        BMR_REG_SRAM = 2'b11
    } bmr_region_e;
    // =========================================================
    // access size, as on the usual system bus
    typedef enum logic [1:0] {
        BMR_SIZE_BYTE = 2'b00,
        BMR_SIZE_HALF = 2'b01,
        BMR_SIZE_WORD = 2'b10
    } bmr_size_e;
endpackage

// ==== include/bmr_sram_if.sv ====
// interface: port between remap logic and the embedded sram
`timescale 1ns/1ns
interface bmr_sram_if #(
    parameter int AW = 11
);
    logic en;
    logic we;
    logic [3:0] be;
    logic [AW-1:0] widx;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport ctrl (output en, output we, output be, output widx, output wdata, input rdata);
    modport mem (input en, input we, input be, input widx, input wdata, output rdata);
endinterface

// ==== design/bmr_sram.sv ====
// module: embedded sram with byte lane writes
`timescale 1ns/1ns
module bmr_sram #(
    parameter int WORDS = bmr_pkg::BMR_SRAM_WORDS,
    parameter int AW = 11
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // access port
    bmr_sram_if.mem port
);
    typedef struct packed {
        logic [31:0] rdata;
    } bmr_sram_s;

    // storage holds data only: no parity bits are kept or checked
    logic [31:0] rd_word;
    bmr_sram_s state_reg;
    bmr_sram_s state_next;

    // =========================================================
    // read path; data is zero when not read so the top can pass it on
    always_comb begin
        state_next = '0;
        if (port.en && !port.we) begin
            state_next.rdata = rd_word;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // write path, one generate lane per byte; each lane owns its array so no word has two writers
    for (genvar b = 0; b < 4; b++) begin : g_lane
        logic [7:0] lane_mem [WORDS];
        always_ff @(posedge sys_clk_i) begin
            if (port.en && port.we && port.be[b]) begin
                lane_mem[port.widx] <= port.wdata[8*b +: 8]; // RULE8
            end
        end
        // lanes join again into one word for the read flop
        assign rd_word[8*b +: 8] = lane_mem[port.widx];
    end

    assign port.rdata = state_reg.rdata; // RULE9
endmodule

// ==== design/bmr_boot_remap.sv ====
// module: startup memory selection and boot space remap
// Overview of operation
// [RULE1] boot pin low: main flash aliased at zero and still at its own base
// [RULE2] second select low, pin high: system memory aliased at zero, own base too
// [RULE3] both high: boot from sram, reachable only at its own base
// [RULE4] second select is the inverse of the nonvolatile option bit
// [RULE5] startup mode taken after reset from pin and option-derived select
// [RULE6] on standby exit the boot pin level is latched to pick startup memory
// [RULE7] outside party holds the boot pin steady through standby
// [RULE8] sram accepts byte, halfword and word accesses
// [RULE9] sram keeps no parity and does no parity check
// [RULE10] startup selection stays fixed except at reset or standby exit
`timescale 1ns/1ns
module bmr_boot_remap #(
    parameter logic [31:0] FLASH_BYTES = bmr_pkg::BMR_FLASH_BYTES,
    parameter logic [31:0] SYSMEM_BYTES = bmr_pkg::BMR_SYSMEM_BYTES,
    parameter int SRAM_WORDS = bmr_pkg::BMR_SRAM_WORDS
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // boot straps and power events
    input wire logic boot_select_pin_i,
    input wire logic boot_select_option_inverted_i,
    input wire logic standby_exit_i,
    // access from the bus masters
    input wire logic req_i,
    input wire logic write_i,
    input wire logic [1:0] size_i,
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    // answer to the bus masters
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [31:0] rdata_o,
    // forward to flash and system memory
    output logic fwd_valid_o,
    output logic [1:0] fwd_region_o,
    output logic [31:0] fwd_offset_o,
    output logic fwd_write_o,
    output logic [1:0] fwd_size_o,
    output logic [31:0] fwd_wdata_o,
    // startup state
    output logic [1:0] boot_mode_o,
    output logic boot_valid_o
);
    localparam int AW = (SRAM_WORDS > 1) ? $clog2(SRAM_WORDS) : 1;
    localparam logic [31:0] SRAM_BYTES = 32'(SRAM_WORDS) << 2;

    typedef struct packed {
        bmr_pkg::bmr_boot_e mode;
        logic captured;
        logic rsp_valid;
        logic rsp_err;
        logic fwd_valid;
        bmr_pkg::bmr_region_e fwd_region;
        logic [31:0] fwd_offset;
        logic fwd_write;
        logic [1:0] fwd_size;
        logic [31:0] fwd_wdata;
    } bmr_state_s;

    bmr_state_s state_reg;
    bmr_state_s state_next;
    bmr_sram_if #(.AW(AW)) sram_bus ();

    logic boot_select_second;
    bmr_pkg::bmr_boot_e mode_sampled;
    bmr_pkg::bmr_region_e region;
    logic [31:0] offset;
    logic aligned;
    logic size_ok;
    logic [3:0] lanes;

    // =========================================================
    // startup mode from straps
    assign boot_select_second = ~boot_select_option_inverted_i; // RULE4

    // pin low wins whatever the second select says
    always_comb begin
        if (!boot_select_pin_i) begin
            mode_sampled = bmr_pkg::BMR_BOOT_FLASH; // RULE1
        end else if (!boot_select_second) begin
            mode_sampled = bmr_pkg::BMR_BOOT_SYSMEM; // RULE2
        end else begin
            mode_sampled = bmr_pkg::BMR_BOOT_SRAM; // RULE3
        end
    end

    // =========================================================
    // address decode against the latched mode
    always_comb begin
        region = bmr_pkg::BMR_REG_NONE;
        offset = '0;
        if ((addr_i - bmr_pkg::BMR_FLASH_BASE) < FLASH_BYTES) begin
            region = bmr_pkg::BMR_REG_FLASH; // RULE1
            offset = addr_i - bmr_pkg::BMR_FLASH_BASE;
        end else if ((addr_i - bmr_pkg::BMR_SYSMEM_BASE) < SYSMEM_BYTES) begin
            region = bmr_pkg::BMR_REG_SYSMEM; // RULE2
            offset = addr_i - bmr_pkg::BMR_SYSMEM_BASE;
        end else if ((addr_i - bmr_pkg::BMR_SRAM_BASE) < SRAM_BYTES) begin
            region = bmr_pkg::BMR_REG_SRAM; // RULE3
            offset = addr_i - bmr_pkg::BMR_SRAM_BASE;
        end else if (state_reg.captured) begin
            // boot space alias; nothing is aliased while booting from sram
            unique case (state_reg.mode)
                bmr_pkg::BMR_BOOT_FLASH: begin
                    if ((addr_i - bmr_pkg::BMR_BOOT_BASE) < FLASH_BYTES) begin
                        region = bmr_pkg::BMR_REG_FLASH; // RULE1
                        offset = addr_i - bmr_pkg::BMR_BOOT_BASE;
                    end
                end
                bmr_pkg::BMR_BOOT_SYSMEM: begin
                    if ((addr_i - bmr_pkg::BMR_BOOT_BASE) < SYSMEM_BYTES) begin
                        region = bmr_pkg::BMR_REG_SYSMEM; // RULE2
                        offset = addr_i - bmr_pkg::BMR_BOOT_BASE;
                    end
                end
                bmr_pkg::BMR_BOOT_SRAM: begin
                    region = bmr_pkg::BMR_REG_NONE; // RULE3
                end
                default: begin
                    region = bmr_pkg::BMR_REG_NONE;
                end
            endcase
        end
    end

    // =========================================================
    // size check and byte lanes; misaligned accesses are refused
    always_comb begin
        lanes = 4'h0;
        size_ok = 1'b1;
        aligned = 1'b1;
        unique case (size_i)
            bmr_pkg::BMR_SIZE_BYTE: begin
                lanes = 4'h1 << addr_i[1:0]; // RULE8
            end
            bmr_pkg::BMR_SIZE_HALF: begin
                aligned = ~addr_i[0];
                lanes = addr_i[1] ? 4'hc : 4'h3; // RULE8
            end
            bmr_pkg::BMR_SIZE_WORD: begin
                aligned = (addr_i[1:0] == 2'h0);
                lanes = 4'hf; // RULE8
            end
            default: begin
                size_ok = 1'b0;
            end
        endcase
    end

    // =========================================================
    // sram port is driven in the request cycle, answered next cycle
    assign sram_bus.en = req_i && size_ok && aligned && (region == bmr_pkg::BMR_REG_SRAM);
    assign sram_bus.we = write_i;
    assign sram_bus.be = lanes;
    assign sram_bus.widx = offset[AW+1:2];
    assign sram_bus.wdata = wdata_i;

    // =========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.rsp_valid = 1'b0;
        state_next.rsp_err = 1'b0;
        state_next.fwd_valid = 1'b0;
        // straps are caught once after reset release and again at each standby exit, otherwise held
        if (!state_reg.captured || standby_exit_i) begin
            state_next.mode = mode_sampled; // RULE5 RULE6 RULE10
            state_next.captured = 1'b1;
        end
        // requests before the straps are caught find no boot alias
        if (req_i) begin
            if (!size_ok || !aligned || region == bmr_pkg::BMR_REG_NONE) begin
                state_next.rsp_valid = 1'b1;
                state_next.rsp_err = 1'b1;
            end else if (region == bmr_pkg::BMR_REG_SRAM) begin
                state_next.rsp_valid = 1'b1;
            end else begin
                state_next.fwd_valid = 1'b1;
                state_next.fwd_region = region;
                state_next.fwd_offset = offset;
                state_next.fwd_write = write_i;
                state_next.fwd_size = size_i;
                state_next.fwd_wdata = wdata_i;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= '{mode: bmr_pkg::BMR_BOOT_RESET, fwd_region: bmr_pkg::BMR_REG_NONE, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // =========================================================
    // embedded sram
    bmr_sram #(
        .WORDS(SRAM_WORDS),
        .AW(AW)
    ) u_sram (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .port(sram_bus.mem)
    );

    // =========================================================
    // outputs, all from flip-flops
    assign rsp_valid_o = state_reg.rsp_valid;
    assign rsp_err_o = state_reg.rsp_err;
    assign rdata_o = sram_bus.rdata; // zero unless an sram read answered
    assign fwd_valid_o = state_reg.fwd_valid;
    assign fwd_region_o = state_reg.fwd_region;
    assign fwd_offset_o = state_reg.fwd_offset;
    assign fwd_write_o = state_reg.fwd_write;
    assign fwd_size_o = state_reg.fwd_size;
    assign fwd_wdata_o = state_reg.fwd_wdata;
    assign boot_mode_o = state_reg.mode;
    assign boot_valid_o = state_reg.captured;
endmodule

// ==== tb/bmr_sva.sv ====
// checker: port-level properties of the boot remap block
`timescale 1ns/1ns
module bmr_sva (
    // clock, reset and straps
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic boot_select_pin_i,
    input wire logic boot_select_option_inverted_i,
    input wire logic standby_exit_i,
    // bus side
    input wire logic req_i,
    input wire logic [1:0] size_i,
    input wire logic [31:0] addr_i,
    input wire logic rsp_valid_o,
    input wire logic rsp_err_o,
    input wire logic fwd_valid_o,
    input wire logic [1:0] fwd_region_o,
    input wire logic [31:0] fwd_offset_o,
    input wire logic [1:0] boot_mode_o,
    input wire logic boot_valid_o
);
    // =========================================================
    // helpers
    // mode the straps ask for right now
    wire logic [1:0] strap_mode = !boot_select_pin_i ? 2'h0 : (boot_select_option_inverted_i ? 2'h1 : 2'h2);
    // aligned word access while the mode cannot move under it
    wire logic ok = req_i && !standby_exit_i && boot_valid_o && size_i == 2'h2 && addr_i[1:0] == 2'h0;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // =========================================================
    // assertions
    a_strap_relatch: assert property (standby_exit_i |=> boot_mode_o == $past(strap_mode))
        else $error("standby exit picked the wrong mode");
    a_first_strap: assert property ($rose(boot_valid_o) |-> boot_mode_o == $past(strap_mode))
        else $error("mode after reset wrong");
    a_mode_hold: assert property (boot_valid_o && !standby_exit_i |=> $stable(boot_mode_o))
        else $error("mode moved without cause");
    a_flash_alias: assert property (ok && boot_mode_o == 2'h0 && addr_i < bmr_pkg::BMR_FLASH_BYTES
        |=> fwd_valid_o && fwd_region_o == 2'h1 && fwd_offset_o == $past(addr_i)) else $error("flash alias wrong");
    a_flash_own: assert property (ok && addr_i[31:16] == 16'h0800 |=> fwd_valid_o && fwd_region_o == 2'h1
        && fwd_offset_o == $past(addr_i) - bmr_pkg::BMR_FLASH_BASE) else $error("flash base wrong");
    a_sys_alias: assert property (ok && boot_mode_o == 2'h1 && addr_i < bmr_pkg::BMR_SYSMEM_BYTES
        |=> fwd_valid_o && fwd_region_o == 2'h2 && fwd_offset_o == $past(addr_i)) else $error("sysmem alias wrong");
    a_sram_hidden: assert property (ok && boot_mode_o == 2'h2 && addr_i < 32'h0000_2000
        |=> rsp_valid_o && rsp_err_o && !fwd_valid_o) else $error("sram seen through alias");
    a_bad_size: assert property (req_i && size_i == 2'h3 |=> rsp_valid_o && rsp_err_o)
        else $error("illegal size accepted");
    a_sram_sizes: assert property (req_i && addr_i[31:13] == 19'h10000 && (size_i == 2'h0
        || size_i == 2'h1 && !addr_i[0] || size_i == 2'h2 && addr_i[1:0] == 2'h0)
        |=> rsp_valid_o && !rsp_err_o && !fwd_valid_o) else $error("sram access refused");
    // main scenarios reached
    c_sram_mode: cover property (standby_exit_i ##1 boot_mode_o == 2'h2);
    c_sys_fwd: cover property (fwd_valid_o && fwd_region_o == 2'h2);
    c_error: cover property (rsp_valid_o && rsp_err_o);
endmodule

// ==== tb/bmr_master.sv ====
// partner: bus master issuing single accesses to the remap block
`timescale 1ns/1ns
module bmr_master (
    // clock and answers
    input wire logic sys_clk_i,
    input wire logic rsp_valid_i,
    input wire logic rsp_err_i,
    input wire logic fwd_valid_i,
    input wire logic [31:0] rdata_i,
    // request
    output logic req_o,
    output logic write_o,
    output logic [1:0] size_o,
    output logic [31:0] addr_o,
    output logic [31:0] wdata_o
);
    // idle bus at time zero
    initial {req_o, write_o, size_o, addr_o, wdata_o} = '0;
    // one access; status comes back as valid, error, forwarded
    task automatic access(input logic w, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d,
            output logic [2:0] st, output logic [31:0] q);
        @(posedge sys_clk_i);
        req_o <= 1'b1;
        write_o <= w;
        size_o <= s;
        addr_o <= a;
        wdata_o <= d;
        @(posedge sys_clk_i);
        // address and write data flip so a stale value never looks valid
        req_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        st = {rsp_valid_i, rsp_err_i, fwd_valid_i};
        q = rdata_i;
    endtask
endmodule

// ==== tb/tb.sv ====
// testbench: straps, remap and sram accesses against the boot remap block
`timescale 1ns/1ns
module tb;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic boot_select_pin_i = 1'b0;
    logic boot_select_option_inverted_i = 1'b1;
    logic standby_exit_i = 1'b0;
    logic req_i, write_i, rsp_valid_o, rsp_err_o, fwd_valid_o, fwd_write_o, boot_valid_o;
    logic [1:0] size_i, fwd_region_o, fwd_size_o, boot_mode_o, s;
    logic [31:0] addr_i, wdata_i, rdata_o, fwd_offset_o, fwd_wdata_o, a, d, old, q, off;
    int bad_count = 0;
    int check_count = 0;
    int cycles = 0;
    bmr_boot_remap dut_u (.sys_clk_i, .rstn_i, .boot_select_pin_i, .boot_select_option_inverted_i,
        .standby_exit_i, .req_i, .write_i, .size_i, .addr_i, .wdata_i, .rsp_valid_o, .rsp_err_o, .rdata_o,
        .fwd_valid_o, .fwd_region_o, .fwd_offset_o, .fwd_write_o, .fwd_size_o, .fwd_wdata_o, .boot_mode_o,
        .boot_valid_o);
    bmr_master master_u (.sys_clk_i, .rsp_valid_i(rsp_valid_o), .rsp_err_i(rsp_err_o), .fwd_valid_i(fwd_valid_o),
        .rdata_i(rdata_o), .req_o(req_i), .write_o(write_i), .size_o(size_i), .addr_o(addr_i), .wdata_o(wdata_i));
    // =========================================================
    // clock and hang guard; run needs a few hundred cycles
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            close_out();
        end
    end
    // =========================================================
    // helpers
    function automatic logic [1:0] exp_mode(input logic p, input logic o);
        return !p ? 2'h0 : (o ? 2'h1 : 2'h2);
    endfunction
    // only the lanes picked by size and offset take new data
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [1:0] sz,
            input logic [1:0] of);
        logic [31:0] m;
        m = sz == 2'h0 ? 32'hff << {of, 3'h0} : (sz == 2'h1 ? 32'hffff << {of, 3'h0} : 32'hffff_ffff);
        return (o & ~m) | (n & m);
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // pin settles a cycle before the standby exit pulse
    task strap(input logic p, input logic o);
        @(posedge sys_clk_i);
        boot_select_pin_i <= p;
        boot_select_option_inverted_i <= o;
        @(posedge sys_clk_i);
        standby_exit_i <= 1'b1;
        @(posedge sys_clk_i);
        standby_exit_i <= 1'b0;
        #1 chk({30'h0, boot_mode_o}, {30'h0, exp_mode(p, o)});
    endtask
    task automatic go(input logic w, input logic [1:0] sz, input logic [31:0] ad, input logic [31:0] dt,
            input logic [2:0] est, output logic [31:0] rd);
        logic [2:0] st;
        master_u.access(w, sz, ad, dt, st, rd);
        chk({29'h0, st}, {29'h0, est});
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // =========================================================
    // main sequence
    initial begin
        void'($urandom(32'hc20d));
        repeat (2) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        // every strap pair through reset, then a stray pin change, then standby exit
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            rstn_i <= 1'b0;
            boot_select_pin_i <= i[1];
            boot_select_option_inverted_i <= i[0];
            #1 chk({29'h0, boot_valid_o, boot_mode_o}, 32'h0);
            repeat (2) @(posedge sys_clk_i);
            rstn_i <= 1'b1;
            repeat (2) @(posedge sys_clk_i);
            #1 chk({29'h0, boot_valid_o, boot_mode_o}, {29'h0, 1'b1, exp_mode(i[1], i[0])});
            @(posedge sys_clk_i);
            boot_select_pin_i <= !i[1];
            repeat (3) @(posedge sys_clk_i);
            #1 chk({30'h0, boot_mode_o}, {30'h0, exp_mode(i[1], i[0])});
            strap(!i[1], i[0]);
        end
        $display("test strap decode done");
        // boot space alias and the flash and system memory own bases in each mode
        for (int m = 0; m < 3; m++) begin
            strap(m != 0, m == 1);
            off = $urandom_range(0, 32'h13fc) & 32'hffff_fffc;
            go(1'b0, 2'h2, off, 32'h0, m == 2 ? 3'b110 : 3'b001, q);
            if (m != 2) chk({30'h0, fwd_region_o}, m + 1);
            if (m != 2) chk(fwd_offset_o, off);
            d = $urandom;
            go(1'b1, 2'h2, bmr_pkg::BMR_FLASH_BASE + off, d, 3'b001, q);
            chk(fwd_offset_o, off);
            chk(fwd_wdata_o, d);
            chk({29'h0, fwd_write_o, fwd_size_o}, 32'h6);
            go(1'b0, 2'h2, bmr_pkg::BMR_SYSMEM_BASE + off, 32'h0, 3'b001, q);
            chk(fwd_offset_o + {30'h0, fwd_region_o}, off + 2);
        end
        $display("test remap done");
        // sram lanes: full word, then a byte, halfword or word write, then read back
        for (int k = 0; k < 24; k++) begin
            a = bmr_pkg::BMR_SRAM_BASE | (32'($urandom_range(0, 2047)) << 2);
            d = $urandom;
            old = $urandom;
            s = 2'(k % 3);
            off = $urandom & (s == 2'h0 ? 32'h3 : (s == 2'h1 ? 32'h2 : 32'h0));
            go(1'b1, 2'h2, a, old, 3'b100, q);
            go(1'b1, s, a | off, d, 3'b100, q);
            go(1'b0, 2'h2, a, 32'h0, 3'b100, q);
            chk(q, merge(old, d, s, off[1:0]));
        end
        go(1'b0, 2'h3, bmr_pkg::BMR_SRAM_BASE, 32'h0, 3'b110, q);
        go(1'b1, 2'h1, bmr_pkg::BMR_SRAM_BASE | 32'h1, 32'h0, 3'b110, q);
        $display("test sram sizes done");
        close_out();
    end
endmodule
bind bmr_boot_remap bmr_sva sva_u (.sys_clk_i, .rstn_i, .boot_select_pin_i, .boot_select_option_inverted_i,
    .standby_exit_i, .req_i, .size_i, .addr_i, .rsp_valid_o, .rsp_err_o, .fwd_valid_o, .fwd_region_o,
    .fwd_offset_o, .boot_mode_o, .boot_valid_o);
